// ### bench/sfwg_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module sfwg_spi_master (
  // Clock.
  input wire logic mclk,
  // Serial pins.
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so
);
  // ----------------------------------------
  // Serial link master.
  // ----------------------------------------
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    si = 1'h0;
  end
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    @(posedge mclk) cs_n <= 1'h0;
    for (int i = 0; i < n; i++) begin
      si <= tx[39-i];
      repeat (4) @(posedge mclk);
      sclk <= 1'h1;
      repeat (4) @(posedge mclk);
      rx = {rx[38:0], so};
      sclk <= 1'h0;
    end
    repeat (4) @(posedge mclk);
    cs_n <= 1'h1;
    si <= ~si;
    repeat (8) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### bench/test_serial_flash_write_guard.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_write_guard;
  // ----------------------------------------
  // Bench for the write guard.
  // ----------------------------------------
  typedef struct {logic [39:0] tx; int n; logic wp; logic [11:0] st;} sfwg_row_t;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic hold_n = 1'h1;
  logic wp_n = 1'h1;
  logic cs_n, sclk, si, so, so_oe, standby;
  logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, r;
  logic [31:0] s_rdata, v;
  logic [39:0] rx;
  int fail_count = 0, comparisons = 0, cycles = 0;
  sfwg_row_t rows [20] = '{
    '{40'h0400000000, 8, 1'h1, 12'hc00}, '{40'h0600000000, 8, 1'h1, 12'hc02},
    '{40'h0400000000, 7, 1'h1, 12'hc02}, '{40'h0104000000, 16, 1'h1, 12'hc04},
    '{40'h0600000000, 8, 1'h1, 12'hc06}, '{40'h2007000000, 32, 1'h1, 12'hc06},
    '{40'h2006ff0000, 32, 1'h1, 12'h407}, '{40'h0500000000, 16, 1'h1, 12'hc04},
    '{40'h0600000000, 8, 1'h0, 12'hc06}, '{40'h0100000000, 16, 1'h0, 12'hc04},
    '{40'hb900000000, 8, 1'h1, 12'hd04}, '{40'h0600000000, 8, 1'h1, 12'hd04},
    '{40'hab00000000, 8, 1'h1, 12'hc04}, '{40'h0600000000, 8, 1'h1, 12'hc06},
    '{40'hc700000000, 8, 1'h1, 12'hc06}, '{40'h0206ff10a5, 40, 1'h1, 12'h407},
    '{40'h0500000000, 16, 1'h1, 12'hc04}, '{40'h2000000000, 32, 1'h1, 12'hc04},
    '{40'h0600000000, 8, 1'h1, 12'hc06}, '{40'h02070000a5, 40, 1'h1, 12'hc06}};
  // Identity values are arbitrary.
  sfwg_top #(.PUW_CYCLES(2000), .MFR_ID(8'h11), .DEV_ID(16'h2233), .SIG_ID(8'h44)) u_sfwg_top (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .standby(standby), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
  sfwg_spi_master u_sfwg_spi_master (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (s_bvalid !== 1'h1);
    rs = s_bresp;
    s_bready <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'h0;
    end while (s_rvalid !== 1'h1);
    d = s_rdata;
    rs = s_rresp;
    s_rready <= 1'h0;
    @(posedge mclk);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    check("so_oe", so_oe, 1'h0);
    check("standby", standby, 1'h1);
    u_sfwg_spi_master.xfer(40'h0600000000, 8, rx);
    u_sfwg_spi_master.xfer(40'h0104000000, 16, rx);
    axi_rd(sfwg_pkg::REG_STATUS, v, r);
    check("early bp", v[4:2], 3'h0);
    repeat (2000) @(posedge mclk);
    foreach (rows[i]) begin
      wp_n <= rows[i].wp;
      u_sfwg_spi_master.xfer(rows[i].tx, rows[i].n, rx);
      axi_rd(sfwg_pkg::REG_STATUS, v, r);
      check("status", v[11:0], rows[i].st);
      for (int k = 0; k < 20000 && standby !== 1'h1; k++) @(posedge mclk);
    end
    axi_wr(sfwg_pkg::REG_CTRL, 32'h1, r);
    u_sfwg_spi_master.xfer(40'h2006f00000, 32, rx);
    axi_rd(sfwg_pkg::REG_STATUS, v, r);
    check("inhibit", v[1:0], 2'h2);
    axi_wr(sfwg_pkg::REG_CTRL, 32'h0, r);
    check("ctrl bresp", r, sfwg_pkg::RESP_OKAY);
    axi_wr(8'h10, 32'h0, r);
    check("bresp", r, sfwg_pkg::RESP_DECERR);
    axi_rd(8'h10, v, r);
    check("rresp", r, sfwg_pkg::RESP_DECERR);
    fork
      u_sfwg_spi_master.xfer(40'h0400000000, 16, rx);
      begin
        repeat (66) @(posedge mclk);
        hold_n <= 1'h0;
        repeat (10) @(posedge mclk);
        axi_rd(sfwg_pkg::REG_STATUS, v, r);
        check("paused", v[9], 1'h1);
        repeat (52) @(posedge mclk);
        hold_n <= 1'h1;
      end
    join
    axi_rd(sfwg_pkg::REG_STATUS, v, r);
    check("pause frame", v[9:0], 10'h004);
    fork
      u_sfwg_spi_master.xfer(40'h9f00000000, 32, rx);
      begin
        repeat (100) @(posedge mclk);
        check("so_oe", so_oe, 1'h1);
      end
    join
    check("ident", rx[23:0], 24'h112233);
    u_sfwg_spi_master.xfer(40'hab00000000, 40, rx);
    check("signature", rx[7:0], 8'h44);
    u_sfwg_spi_master.xfer(40'h0306ff1000, 40, rx);
    check("array", rx[7:0], 8'ha5);
    u_sfwg_spi_master.xfer(40'h0600000000, 8, rx);
    rst <= 1'h1;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    axi_rd(sfwg_pkg::REG_STATUS, v, r);
    check("reset status", v[11:0], 12'h800);
    stop_test();
  end
endmodule
`default_nettype wire

// ### logic/sfwg_top.sv
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sfwg_top #(
  parameter int PUW_CYCLES = sfwg_pkg::PUW_CYCLES_DEF,
  parameter logic [7:0] MFR_ID = 8'h5a,
  parameter logic [15:0] DEV_ID = 16'h1234,
  parameter logic [7:0] SIG_ID = 8'h33
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Serial link pins.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic standby,
  // AXI4-Lite slave.
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  localparam int PUW_W = $clog2(PUW_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection.
  // ----------------------------------------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic sclk_d;
  logic cs_d;
  wire logic cs_s = pin_sync[0];
  wire logic sclk_s = pin_sync[1];
  wire logic si_s = pin_sync[2];
  wire logic hold_s = pin_sync[3];
  wire logic wp_s = pin_sync[4];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta <= 5'h1b;
      pin_sync <= 5'h1b;
      sclk_d <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      pin_meta <= {wp_n, hold_n, si, sclk, cs_n};
      pin_sync <= pin_meta;
      sclk_d <= sclk_s;
      cs_d <= cs_s;
    end
  end

  logic paused;
  wire logic cs_rise = cs_s & ~cs_d;
  wire logic link_on = ~cs_s & ~paused;
  wire logic rise_ok = link_on & sclk_s & ~sclk_d;
  wire logic fall_ok = link_on & ~sclk_s & sclk_d;

  // ----------------------------------------------------------------------
  // Pause control.
  // ----------------------------------------------------------------------
  // pause with clock low.
  wire logic next_paused = cs_s ? 1'b0 :
                           (~paused & ~hold_s & ~sclk_s) ? 1'b1 :
                           (paused & hold_s & ~sclk_s) ? 1'b0 : paused;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      paused <= 1'b0;
    end else begin
      paused <= next_paused;
    end
  end

  // ----------------------------------------------------------------------
  // Storage, status and decode.
  // ----------------------------------------------------------------------
  // byte array.
  logic [7:0] mem [0:sfwg_pkg::MEM_BYTES-1];
  logic [7:0] pbuf [0:255];
  logic [255:0] pvalid;
  logic [2:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic [7:0] sh;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] pp_idx;
  sfwg_pkg::sfwg_tx_t tx_mode;
  logic [7:0] tx_sh;
  logic [2:0] tx_cnt;
  logic [1:0] tx_idx;
  logic [18:0] rd_ptr;
  logic write_enable_latch;
  logic [2:0] bp;
  logic status_write_disable;
  logic dp;
  logic puw_done;
  logic [PUW_W-1:0] puw_cnt;
  logic inhibit;
  logic vfail;
  logic vf_clear;
  sfwg_pkg::sfwg_seq_t seq;
  logic [18:0] walk_a;
  logic [18:0] walk_base;
  logic [18:0] walk_last;
  logic op_erase;

  wire logic busy = (seq != sfwg_pkg::SFWG_IDLE);
  wire logic [7:0] status_byte = {status_write_disable, 2'h0, bp, write_enable_latch, busy};
  wire logic byte_done = rise_ok & (bit_cnt == 3'h7);
  wire logic [7:0] rx_byte = {sh[6:0], si_s};

  function automatic logic prot_hit_f(input logic [2:0] bits, input logic [2:0] blk);
    prot_hit_f = bits[2] | ((bits == 3'h1) & (blk == 3'h7)) |
                 ((bits == 3'h2) & (blk[2:1] == 2'h3)) | ((bits == 3'h3) & blk[2]);
  endfunction

  wire logic prot_hit = prot_hit_f(bp, addr[sfwg_pkg::BLK_LSB+2:sfwg_pkg::BLK_LSB]);
  wire logic cmd_ok = cs_rise & (bit_cnt == 3'h0) & ~busy;
  wire logic live = cmd_ok & ~dp;
  wire logic wr_ok = live & write_enable_latch & puw_done & ~inhibit;
  wire logic op_blk = (opcode == sfwg_pkg::OP_BLK_A) | (opcode == sfwg_pkg::OP_BLK_B);
  wire logic op_chip = (opcode == sfwg_pkg::OP_CHIP_A) | (opcode == sfwg_pkg::OP_CHIP_B);
  wire logic do_write_enable_cmd = live & (opcode == sfwg_pkg::OP_WRITE_ENABLE_CMD) & (byte_cnt == sfwg_pkg::LEN_OP);
  wire logic do_write_disable_cmd = live & (opcode == sfwg_pkg::OP_WRITE_DISABLE_CMD) & (byte_cnt == sfwg_pkg::LEN_OP);
  wire logic do_status_write_cmd = wr_ok & (opcode == sfwg_pkg::OP_STATUS_WRITE_CMD) &
                       (byte_cnt == sfwg_pkg::LEN_STAT);
  wire logic do_se = wr_ok & (opcode == sfwg_pkg::OP_SECT) &
                     (byte_cnt == sfwg_pkg::LEN_ADDR) & ~prot_hit;
  wire logic do_be = wr_ok & op_blk & (byte_cnt == sfwg_pkg::LEN_ADDR) & ~prot_hit;
  wire logic do_ce = wr_ok & op_chip & (byte_cnt == sfwg_pkg::LEN_OP) & (bp == 3'h0);
  wire logic do_pp = wr_ok & (opcode == sfwg_pkg::OP_PROG) &
                     (byte_cnt >= sfwg_pkg::LEN_PROG) & ~prot_hit;
  wire logic do_dp = live & (opcode == sfwg_pkg::OP_DPD) & (byte_cnt == sfwg_pkg::LEN_OP);
  wire logic do_rel = cmd_ok & (opcode == sfwg_pkg::OP_REL) & (byte_cnt != 4'h0);
  wire logic start_op = do_pp | do_se | do_be | do_ce;
  wire logic [18:0] start_mask = do_ce ? sfwg_pkg::MASK_CHIP :
                                 do_be ? sfwg_pkg::MASK_BLOCK :
                                 do_se ? sfwg_pkg::MASK_SECTOR : sfwg_pkg::MASK_PAGE;
  wire logic [18:0] start_base = addr[18:0] & ~start_mask;
  wire logic [7:0] id_byte = (tx_idx == 2'h0) ? MFR_ID :
                             (tx_idx == 2'h1) ? DEV_ID[15:8] : DEV_ID[7:0];
  wire logic [7:0] tx_next = (tx_mode == sfwg_pkg::SFWG_TX_STATUS) ? status_byte :
                             (tx_mode == sfwg_pkg::SFWG_TX_ARRAY) ? mem[rd_ptr] :
                             (tx_mode == sfwg_pkg::SFWG_TX_ID) ? id_byte : SIG_ID;
  wire logic [23:0] next_addr = {addr[15:0], rx_byte};
  wire logic [2:0] first_tx = dp ? sfwg_pkg::SFWG_TX_NONE :
                              (rx_byte == sfwg_pkg::OP_RDSR) ? sfwg_pkg::SFWG_TX_STATUS :
                              (rx_byte == sfwg_pkg::OP_RDID) ? sfwg_pkg::SFWG_TX_ID :
                              sfwg_pkg::SFWG_TX_NONE;
  wire logic rd_array = ~dp & ~busy & (((opcode == sfwg_pkg::OP_READ) &
                        (byte_cnt == sfwg_pkg::BYTE_ADDR_LAST)) |
                        ((opcode == sfwg_pkg::OP_FAST) & (byte_cnt == sfwg_pkg::BYTE_DUMMY)));

  // ----------------------------------------------------------------------
  // Serial receive and transmit.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
      sh <= 8'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
      pp_idx <= 8'h00;
      tx_mode <= sfwg_pkg::SFWG_TX_NONE;
      tx_sh <= 8'h00;
      tx_cnt <= 3'h0;
      tx_idx <= 2'h0;
      rd_ptr <= 19'h00000;
      so <= 1'b0;
    end else if (cs_s) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
      tx_mode <= sfwg_pkg::SFWG_TX_NONE;
      tx_cnt <= 3'h0;
      tx_idx <= 2'h0;
    end else if (rise_ok) begin
      sh <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        byte_cnt <= (byte_cnt == 4'hf) ? byte_cnt : byte_cnt + 4'h1;
        if (byte_cnt == 4'h0) begin
          opcode <= rx_byte;
          tx_mode <= sfwg_pkg::sfwg_tx_t'(first_tx);
        end else if (byte_cnt <= sfwg_pkg::BYTE_ADDR_LAST) begin
          addr <= next_addr;
        end
        if (byte_cnt == sfwg_pkg::BYTE_ADDR_LAST) begin
          pp_idx <= rx_byte;
        end else if (byte_cnt > sfwg_pkg::BYTE_ADDR_LAST) begin
          pp_idx <= pp_idx + 8'h01;
        end
        if (rd_array) begin
          tx_mode <= sfwg_pkg::SFWG_TX_ARRAY;
          rd_ptr <= (opcode == sfwg_pkg::OP_READ) ? next_addr[18:0] : addr[18:0];
        end
        if ((opcode == sfwg_pkg::OP_REL) & (byte_cnt == sfwg_pkg::BYTE_ADDR_LAST)) begin
          tx_mode <= sfwg_pkg::SFWG_TX_SIG;
        end
      end
    end else if (fall_ok & (tx_mode != sfwg_pkg::SFWG_TX_NONE)) begin
      if (tx_cnt == 3'h0) begin
        so <= tx_next[7];
        tx_sh <= {tx_next[6:0], 1'b0};
        tx_cnt <= 3'h7;
        rd_ptr <= rd_ptr + 19'h1;
        tx_idx <= (tx_idx == 2'h2) ? 2'h0 : tx_idx + 2'h1;
      end else begin
        so <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b0};
        tx_cnt <= tx_cnt - 3'h1;
      end
    end
  end

  // Page data captured after the address, wrapping inside the page.
  always_ff @(posedge mclk) begin
    if (byte_done & (opcode == sfwg_pkg::OP_PROG) & (byte_cnt > sfwg_pkg::BYTE_ADDR_LAST)) begin
      pbuf[pp_idx] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Latch, status bits, power state and outputs.
  // ----------------------------------------------------------------------
  wire logic seq_done = (seq == sfwg_pkg::SFWG_CHECK) & (walk_a == walk_last);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pvalid <= 256'h0;
      write_enable_latch <= 1'b0;
      bp <= 3'h0;
      status_write_disable <= 1'b0;
      dp <= 1'b0;
      so_oe <= 1'b0;
      standby <= 1'b1;
    end else begin
      if (cs_s & ~cs_d) begin
        pvalid <= pvalid;
      end else if (~cs_s & cs_d) begin
        pvalid <= 256'h0;
      end else if (byte_done & (opcode == sfwg_pkg::OP_PROG) &
                   (byte_cnt > sfwg_pkg::BYTE_ADDR_LAST)) begin
        pvalid[pp_idx] <= 1'b1;
      end
      if (do_write_disable_cmd | do_status_write_cmd | seq_done) begin
        write_enable_latch <= 1'b0;
      end
      if (do_write_enable_cmd) begin
        write_enable_latch <= 1'b1;
      end
      if (do_status_write_cmd & wp_s) begin
        bp <= addr[4:2];
        status_write_disable <= addr[7];
      end
      if (do_dp) begin
        dp <= 1'b1;
      end else if (do_rel) begin
        dp <= 1'b0;
      end
      so_oe <= ~cs_s & ~paused & (tx_mode != sfwg_pkg::SFWG_TX_NONE);
      standby <= cs_s & ~busy;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      puw_cnt <= '0;
      puw_done <= 1'b0;
    end else if (~puw_done) begin
      puw_cnt <= puw_cnt + PUW_W'(1);
      puw_done <= (puw_cnt == PUW_W'(PUW_CYCLES - 1));
    end
  end

  // ----------------------------------------------------------------------
  // Program and erase sequencer.
  // ----------------------------------------------------------------------
  wire logic [7:0] walk_buf = pbuf[walk_a[7:0]];
  wire logic walk_use = pvalid[walk_a[7:0]];
  wire logic walk_bad = op_erase ? (mem[walk_a] != 8'hff) :
                        (walk_use & ((mem[walk_a] & ~walk_buf) != 8'h00));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq <= sfwg_pkg::SFWG_IDLE;
      walk_a <= 19'h0;
      walk_base <= 19'h0;
      walk_last <= 19'h0;
      op_erase <= 1'b0;
      vfail <= 1'b0;
    end else begin
      if (vf_clear) begin
        vfail <= 1'b0;
      end
      case (seq)
        sfwg_pkg::SFWG_IDLE: begin
          if (start_op) begin
            seq <= sfwg_pkg::SFWG_WALK;
            walk_a <= start_base;
            walk_base <= start_base;
            walk_last <= start_base | start_mask;
            op_erase <= ~do_pp;
          end
        end
        sfwg_pkg::SFWG_WALK: begin
          if (walk_a == walk_last) begin
            seq <= sfwg_pkg::SFWG_CHECK;
            walk_a <= walk_base;
          end else begin
            walk_a <= walk_a + 19'h1;
          end
        end
        sfwg_pkg::SFWG_CHECK: begin
          if (walk_bad) begin
            vfail <= 1'b1;
          end
          if (seq_done) begin
            seq <= sfwg_pkg::SFWG_IDLE;
          end else begin
            walk_a <= walk_a + 19'h1;
          end
        end
        default: begin
          seq <= sfwg_pkg::SFWG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (seq == sfwg_pkg::SFWG_WALK) begin
      mem[walk_a] <= op_erase ? 8'hff : (walk_use ? (mem[walk_a] & walk_buf) : mem[walk_a]);
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite register slave.
  // ----------------------------------------------------------------------
  logic aw_got;
  logic w_got;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic [7:0] last_op;
  logic last_exec;
  wire logic wr_fire = aw_got & w_got & ~s_bvalid;
  wire logic wr_ctrl = wr_fire & (aw_q == sfwg_pkg::REG_CTRL) & ws_q[0];
  assign vf_clear = wr_ctrl & w_q[sfwg_pkg::CTRL_VF_CLEAR];
  wire logic aw_known = (aw_q == sfwg_pkg::REG_STATUS) | (aw_q == sfwg_pkg::REG_CTRL) |
                        (aw_q == sfwg_pkg::REG_LAST);
  wire logic ar_known = (s_araddr == sfwg_pkg::REG_STATUS) | (s_araddr == sfwg_pkg::REG_CTRL) |
                        (s_araddr == sfwg_pkg::REG_LAST);
  wire logic [31:0] rd_mux = (s_araddr == sfwg_pkg::REG_STATUS) ?
                             {19'h0, vfail, standby, puw_done, paused, dp, status_byte} :
                             (s_araddr == sfwg_pkg::REG_CTRL) ? {31'h0, inhibit} :
                             (s_araddr == sfwg_pkg::REG_LAST) ? {23'h0, last_exec, last_op} :
                             32'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= sfwg_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      inhibit <= 1'b0;
    end else begin
      if (s_awvalid & s_awready) begin
        aw_got <= 1'b1;
        aw_q <= {s_awaddr[7:2], 2'h0};
        s_awready <= 1'b0;
      end
      if (s_wvalid & s_wready) begin
        w_got <= 1'b1;
        w_q <= s_wdata;
        ws_q <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= aw_known ? sfwg_pkg::RESP_OKAY : sfwg_pkg::RESP_DECERR;
      end
      if (wr_ctrl) begin
        inhibit <= w_q[sfwg_pkg::CTRL_INHIBIT];
      end
      if (s_bvalid & s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= sfwg_pkg::RESP_OKAY;
      last_op <= 8'h00;
      last_exec <= 1'b0;
    end else begin
      if (s_arvalid & s_arready) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= ar_known ? sfwg_pkg::RESP_OKAY : sfwg_pkg::RESP_DECERR;
      end else if (s_rvalid & s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
      if (cs_rise & (byte_cnt != 4'h0)) begin
        last_op <= opcode;
        last_exec <= do_write_enable_cmd | do_write_disable_cmd | do_status_write_cmd | start_op | do_dp | do_rel;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  a_quiet_deselect: assert property (@(posedge mclk) disable iff (rst)
    cs_s & cs_d |=> ##1 !so_oe) else $error("output enabled while deselected");
  a_boundary_reject: assert property (@(posedge mclk) disable iff (rst)
    cs_rise & ~busy & (bit_cnt != 3'h0) |=> $stable(write_enable_latch) && !$rose(busy))
    else $error("partial byte acted");
  a_wel_needed: assert property (@(posedge mclk) disable iff (rst)
    $rose(busy) |-> $past(write_enable_latch)) else $error("write started without latch");
  a_wel_cleared: assert property (@(posedge mclk) disable iff (rst)
    $fell(busy) |-> !write_enable_latch) else $error("latch kept after operation");
  a_prot_refuse: assert property (@(posedge mclk) disable iff (rst)
    cmd_ok & prot_hit & (opcode == sfwg_pkg::OP_PROG) |=> !busy) else $error("protected program");
  a_wp_freeze: assert property (@(posedge mclk) disable iff (rst)
    !wp_s |=> $stable(bp) && $stable(status_write_disable)) else $error("protect bits changed");
  a_dp_filter: assert property (@(posedge mclk) disable iff (rst)
    dp & cs_rise & (opcode != sfwg_pkg::OP_REL) |=> dp && !busy && $stable(write_enable_latch))
    else $error("command accepted in power-down");
  a_puw_guard: assert property (@(posedge mclk) disable iff (rst)
    !puw_done |=> !busy && $stable(bp) && $stable(status_write_disable)) else $error("write before delay");
  a_pause_freeze: assert property (@(posedge mclk) disable iff (rst)
    paused & ~cs_s |=> $stable(bit_cnt) && $stable(byte_cnt)) else $error("shift during pause");
  a_busy_start: assert property (@(posedge mclk) disable iff (rst)
    start_op |=> busy [*2]) else $error("busy not raised");
endmodule
`default_nettype wire

// ### shared/sfwg_pkg.sv
// ----------------------------------------------------------------------
// Constants shared by the serial flash write guard.
// ----------------------------------------------------------------------
package sfwg_pkg;
  // Array organisation.
  localparam int ADDR_W = 19;
  localparam int MEM_BYTES = 524288;
  localparam logic [18:0] MASK_PAGE = 19'h000ff;
  localparam logic [18:0] MASK_SECTOR = 19'h00fff;
  localparam logic [18:0] MASK_BLOCK = 19'h0ffff;
  localparam logic [18:0] MASK_CHIP = 19'h7ffff;
  localparam int BLK_LSB = 16;
  // Command codes.
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_RDID = 8'h9f;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_SECT = 8'h20;
  localparam logic [7:0] OP_BLK_A = 8'h52;
  localparam logic [7:0] OP_BLK_B = 8'hd8;
  localparam logic [7:0] OP_CHIP_A = 8'h60;
  localparam logic [7:0] OP_CHIP_B = 8'hc7;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_DPD = 8'hb9;
  localparam logic [7:0] OP_REL = 8'hab;
  // Command lengths and byte positions, in bytes.
  localparam logic [3:0] LEN_OP = 4'h1;
  localparam logic [3:0] LEN_STAT = 4'h2;
  localparam logic [3:0] LEN_ADDR = 4'h4;
  localparam logic [3:0] LEN_PROG = 4'h5;
  localparam logic [3:0] BYTE_ADDR_LAST = 4'h3;
  localparam logic [3:0] BYTE_DUMMY = 4'h4;
  // Bus register offsets and fields.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_LAST = 8'h08;
  localparam int CTRL_INHIBIT = 0;
  localparam int CTRL_VF_CLEAR = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Power-up write delay.
  localparam int PUW_US = 10;
  localparam int CLK_MHZ = 40;
  localparam int PUW_CYCLES_DEF = PUW_US * CLK_MHZ;
  typedef enum logic [1:0] {
    SFWG_IDLE = 2'b00,
    SFWG_WALK = 2'b01,
    SFWG_CHECK = 2'b10
  } sfwg_seq_t;
  typedef enum logic [2:0] {
    SFWG_TX_NONE = 3'b000,
    SFWG_TX_STATUS = 3'b001,
    SFWG_TX_ARRAY = 3'b010,
    SFWG_TX_ID = 3'b011,
    SFWG_TX_SIG = 3'b100
  } sfwg_tx_t;
endpackage
